// ### prs_board_model.sv
// Board reset source, pulled-up reset wires and PLL lock model
module prs_board_model (
    input wire logic ref_clk, // Clock
    input wire logic porReq, // Hold board reset
    input wire logic [11:0] lockCyc, // Lock delay
    input wire logic pllStart, // PLL released
    input wire logic hardPull, // Board pulls hard
    input wire logic softPull, // Board pulls soft
    input wire logic hardResetPinOe, // Device hard drive
    input wire logic softResetPinOe, // Device soft drive
    output logic powerOnResetInN, // Board reset
    output logic pllLocked, // Lock flag
    output logic hardResetPinIn, // Hard wire
    output logic softResetPinIn // Soft wire
);
    logic [4:0] porCnt_q = 5'h14;
    logic [11:0] lockCnt_q = 12'h000;
    always @(posedge ref_clk) begin
        porCnt_q <= porReq ? 5'h14 : porCnt_q - {4'h0, porCnt_q != 5'h00};
        lockCnt_q <= !pllStart ? 12'h000 : lockCnt_q + {11'h000, lockCnt_q != lockCyc};
    end
    assign powerOnResetInN = porCnt_q == 5'h00;
    assign pllLocked = pllStart && lockCnt_q == lockCyc;
    // Pull-ups: a wire is low while either side pulls it
    assign hardResetPinIn = hardResetPinOe && !hardPull;
    assign softResetPinIn = softResetPinOe && !softPull;
endmodule

// ### prs_pkg.sv
// Constants, types and register map of the power-on reset sequencer
package prs_pkg;

    // ****
    // Clock and sequence counts
    // ****
    localparam logic [11:0] CFG_CYC = 12'h0400;       // 1024 input clocks
    localparam logic [11:0] DLL_LOCK_CYC = 12'h0C01;  // 3073 bus clocks
    localparam logic [11:0] HARD_HOLD_CYC = 12'h0200; // 512 bus clocks
    localparam logic [11:0] SOFT_LAG_CYC = 12'h0003;  // Three bus clocks
    localparam logic [11:0] PIN_SETTLE_CYC = 12'h0002; // Pin sync latency
    localparam logic [2:0] HOST_BYTES = 3'h4;

    // ****
    // Register map (byte addresses)
    // ****
    localparam int AW = 8;
    localparam logic [AW-1:0] OFS_STATUS = 8'h00;
    localparam logic [AW-1:0] OFS_CFGWORD = 8'h04;
    localparam logic [AW-1:0] OFS_HOSTCFG = 8'h08;
    localparam logic [AW-1:0] OFS_CONTROL = 8'h0C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Reset configuration word fields
    localparam int CFG_MODCKH_LSB = 24;
    localparam int CFG_MODCKH_W = 4;
    localparam int CFG_DLLBYP_POS = 15;
    localparam logic [31:0] CFG_WORD_RST = 32'h0000_0000;

    // Control register fields
    localparam int CTL_SWHARD_POS = 0;

    typedef enum logic [2:0] {
        SEQ_POR = 3'b000,
        SEQ_CFG = 3'b001,
        SEQ_HOST = 3'b010,
        SEQ_PLL = 3'b011,
        SEQ_DLL = 3'b100,
        SEQ_HOLD = 3'b101,
        SEQ_SOFT = 3'b110,
        SEQ_RUN = 3'b111
    } prs_seq_e;

    typedef struct packed {
        logic [2:0] clockModeStraps;
        logic [1:0] bootSourceStrap;
        logic hostPortEnableStrap;
        logic debugRequestStrap;
        logic configRoleStrap;
    } prs_strap_s;

endpackage

// ### prs_seq_assertions.sv
// Port-level checker of the reset sequencer
module prs_seq_assertions (
    input wire logic ref_clk, // Clock
    input wire logic rstn, // Reset
    input wire logic powerOnResetInN, // Board reset
    input wire prs_pkg::prs_strap_s straps, // Straps
    input wire logic pllLocked, // Lock flag
    input wire logic internalPorN, // Internal reset
    input wire logic hardResetN, // Hard reset
    input wire logic softResetN, // Soft reset
    input wire logic hardResetPinOe, // Hard pin enable
    input wire logic softResetPinOe, // Soft pin enable
    input wire logic clocksEnable, // Clocks on
    input wire logic dllBypass, // DLL bypass
    input wire logic debugMode, // Debug start
    input wire logic hostPortEnable, // Host port
    input wire logic configMaster, // Master role
    input wire logic [1:0] bootSource // Boot select
);
    // ****
    // Cycle counters
    // ****
    logic [11:0] cfgCnt_q;
    logic [11:0] lockCnt_q;
    logic porRun_q;
    // Cleared by the board reset, so the count starts at its rising edge
    always_ff @(posedge ref_clk) begin
        cfgCnt_q <= !powerOnResetInN ? 12'h000 : cfgCnt_q + {11'h000, !internalPorN};
        lockCnt_q <= (!clocksEnable || hardResetN) ? 12'h000 : lockCnt_q + 12'h001;
        porRun_q <= !internalPorN ? 1'b1 : (hardResetN ? 1'b0 : porRun_q);
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence s_softLag;
        !softResetN [*3] ##1 softResetN;
    endsequence
    property p_porAll;
        !powerOnResetInN |=> !internalPorN && !hardResetN && !softResetN;
    endproperty
    a_porAll: assert property (p_porAll) else $error("Board reset not passed on");
    property p_softInHard; !hardResetN |-> !softResetN; endproperty
    a_softInHard: assert property (p_softInHard) else $error("Soft released in hard");
    property p_openDrain;
        hardResetPinOe == hardResetN && softResetPinOe == softResetN;
    endproperty
    a_openDrain: assert property (p_openDrain) else $error("Pin drive mismatch");
    property p_cfgTime;
        $rose(internalPorN) && !hostPortEnable |-> cfgCnt_q == prs_pkg::CFG_CYC + 12'h001;
    endproperty
    a_cfgTime: assert property (p_cfgTime) else $error("Configuration length wrong");
    property p_seqHeld;
        (!internalPorN || !clocksEnable) |-> !hardResetN && !softResetN;
    endproperty
    a_seqHeld: assert property (p_seqHeld) else $error("Reset dropped early");
    property p_lockEn;
        powerOnResetInN && internalPorN && !clocksEnable && pllLocked |=> clocksEnable;
    endproperty
    a_lockEn: assert property (p_lockEn) else $error("Clocks not enabled on lock");
    property p_holdTime;
        $rose(hardResetN) && porRun_q |-> lockCnt_q == (dllBypass ? prs_pkg::HARD_HOLD_CYC
            : prs_pkg::HARD_HOLD_CYC + prs_pkg::DLL_LOCK_CYC);
    endproperty
    a_holdTime: assert property (p_holdTime) else $error("Hard hold wrong");
    property p_softLag; $rose(hardResetN) |-> s_softLag; endproperty
    a_softLag: assert property (p_softLag) else $error("Soft lag wrong");
    property p_strapCap;
        $rose(powerOnResetInN) |=> configMaster == !$past(straps.configRoleStrap)
            && hostPortEnable == $past(straps.hostPortEnableStrap)
            && bootSource == $past(straps.bootSourceStrap);
    endproperty
    a_strapCap: assert property (p_strapCap) else $error("Strap capture wrong");
    property p_debugCap;
        $rose(clocksEnable) |-> debugMode == $past(straps.debugRequestStrap);
    endproperty
    a_debugCap: assert property (p_debugCap) else $error("Debug capture wrong");
endmodule

bind prs_sequencer prs_seq_assertions u_chk (.*);

// ### prs_sequencer.sv
// Power-on reset sequencer with strap capture and AXI4-Lite registers
//
// Overview of operation
// - Board reset low: internal, hard, soft reset asserted at once.
// - Role strap caught on board reset rise: 0 master, 1 slave.
// - Debug strap caught at PLL lock: 1 enters debug mode.
// - Host port strap caught on rise: 1 enables host port.
// - Boot strap caught on rise: 00 memory, 01 host port.
// - Status register records latest reset sources.
// - Soft reset held in hard reset; hard pin open-drain.
// - Outside reset seen only while not driving; soft pin open-drain.
// - Hard reset clears all; soft reset keeps configuration. Here hard reset also keeps the word and straps.
// - 1024 configuration clocks, then clock mode straps caught.
// - PLL ratio from clock mode straps and word high field.
// - Wait for PLL lock, then enable clocks.
// - DLL bypass clear: 3073 clocks DLL lock wait.
// - DLL bypass set: no DLL lock wait.
// - Hard reset held through locking plus 512 clocks.
// - Soft reset released three clocks after hard reset.
// - Hard and soft reset held through power-on sequence.
// - Host mode: internal reset held until word written.
// - Host port off: hardware configuration, master or slave.
module prs_sequencer #(
    parameter logic [31:0] HW_CFG_WORD = prs_pkg::CFG_WORD_RST
) (
    input wire logic ref_clk,  // 25 MHz clock
    input wire logic rstn,  // Synchronous reset, active low
    input wire logic powerOnResetInN,  // External power-on reset
    input wire prs_pkg::prs_strap_s straps,  // Configuration straps
    input wire logic hardResetPinIn,  // Hard reset pin level
    output logic hardResetPinOut,  // Hard reset pin drive value
    output logic hardResetPinOe,  // Low while driving
    input wire logic softResetPinIn,  // Soft reset pin level
    output logic softResetPinOut,  // Soft reset pin drive value
    output logic softResetPinOe,  // Low while driving
    input wire logic pllLocked,  // System PLL lock
    output logic internalPorN,  // Internal power-on reset
    output logic hardResetN,  // Hard reset domain
    output logic softResetN,  // Soft reset domain
    output logic pllStart,  // PLL may start locking
    output logic [6:0] pllRatio,  // Clock ratio select
    output logic dllBypass,  // DLL bypassed
    output logic clocksEnable,  // Device clocks enabled
    output logic debugMode,  // Core starts in debug
    output logic hostPortEnable,  // Host port enabled
    output logic configMaster,  // Configuration master
    output logic [1:0] bootSource,  // Boot source select
    input wire logic [7:0] s_axi_awaddr,  // Write address
    input wire logic s_axi_awvalid,  // Write address valid
    output logic s_axi_awready,  // Write address ready
    input wire logic [31:0] s_axi_wdata,  // Write data
    input wire logic [3:0] s_axi_wstrb,  // Write strobes
    input wire logic s_axi_wvalid,  // Write data valid
    output logic s_axi_wready,  // Write data ready
    output logic [1:0] s_axi_bresp,  // Write response
    output logic s_axi_bvalid,  // Write response valid
    input wire logic s_axi_bready,  // Write response ready
    input wire logic [7:0] s_axi_araddr,  // Read address
    input wire logic s_axi_arvalid,  // Read address valid
    output logic s_axi_arready,  // Read address ready
    output logic [31:0] s_axi_rdata,  // Read data
    output logic [1:0] s_axi_rresp,  // Read response
    output logic s_axi_rvalid,  // Read data valid
    input wire logic s_axi_rready  // Read data ready
);

    // ****
    // Declarations
    // ****
    prs_pkg::prs_seq_e state_q;
    prs_pkg::prs_seq_e state_d;
    logic [11:0] cnt_q;
    logic [11:0] cnt_d;
    logic porPrev_q;
    logic [1:0] pinSync;
    logic hardPinSync;
    logic softPinSync;
    prs_pkg::prs_strap_s strap_q;
    logic [31:0] cfgWord_q;
    logic [2:0] hostBytes_q;
    logic [3:0] cause_q;
    logic hardRstN_q;
    logic softRstN_q;
    logic intPorN_q;
    logic clkEn_q;
    logic awHeld_q;
    logic wHeld_q;
    logic [7:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic bValid_q;
    logic [1:0] bResp_q;
    logic rValid_q;
    logic [31:0] rData_q;
    logic [1:0] rResp_q;

    // ****
    // Address decoding
    // ****
    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a == prs_pkg::OFS_STATUS) || (a == prs_pkg::OFS_CFGWORD) ||
                   (a == prs_pkg::OFS_HOSTCFG) || (a == prs_pkg::OFS_CONTROL);
    endfunction

    // ****
    // Pin synchronisers
    // ****
    prs_sync #(
        .W(2)
    ) u_pinSync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .asyncIn({softResetPinIn, hardResetPinIn}),
        .syncOut(pinSync)
    );

    assign hardPinSync = pinSync[0];
    assign softPinSync = pinSync[1];

    // ****
    // Sequence events
    // ****
    wire porLow = !powerOnResetInN;
    wire porRise = powerOnResetInN && !porPrev_q;
    wire cntDone = (cnt_q == 12'h000);
    wire wrFire = awHeld_q && wHeld_q && !bValid_q;
    wire wrHost = wrFire && (awAddr_q == prs_pkg::OFS_HOSTCFG) && wStrb_q[0];
    wire wrCtl = wrFire && (awAddr_q == prs_pkg::OFS_CONTROL) && wStrb_q[0];
    wire swHardReq = wrCtl && wData_q[prs_pkg::CTL_SWHARD_POS];
    // Pins count only once our release has passed the sync
    wire notDriving = hardRstN_q && softRstN_q && cntDone;
    wire extHard = notDriving && !hardPinSync;
    wire extSoft = notDriving && !softPinSync;
    wire hostDone = (hostBytes_q == prs_pkg::HOST_BYTES);
    wire bypassDll = cfgWord_q[prs_pkg::CFG_DLLBYP_POS];

    // ****
    // Next-state logic
    // ****
    always_comb begin
        state_d = state_q;
        cnt_d = cntDone ? cnt_q : cnt_q - 12'h001;
        case (state_q)
            prs_pkg::SEQ_POR: begin
                if (porRise) begin
                    state_d = prs_pkg::SEQ_CFG;
                    cnt_d = prs_pkg::CFG_CYC - 12'h001;
                end
            end
            prs_pkg::SEQ_CFG: begin
                if (cntDone) begin
                    // Host mode waits for the word
                    state_d = strap_q.hostPortEnableStrap ?
                              prs_pkg::SEQ_HOST : prs_pkg::SEQ_PLL;
                end
            end
            prs_pkg::SEQ_HOST: begin
                if (hostDone) begin
                    state_d = prs_pkg::SEQ_PLL;
                end
            end
            prs_pkg::SEQ_PLL: begin
                if (pllLocked) begin
                    if (bypassDll) begin
                        state_d = prs_pkg::SEQ_HOLD;
                        cnt_d = prs_pkg::HARD_HOLD_CYC - 12'h001;
                    end else begin
                        state_d = prs_pkg::SEQ_DLL;
                        cnt_d = prs_pkg::DLL_LOCK_CYC - 12'h001;
                    end
                end
            end
            prs_pkg::SEQ_DLL: begin
                if (cntDone) begin
                    state_d = prs_pkg::SEQ_HOLD;
                    cnt_d = prs_pkg::HARD_HOLD_CYC - 12'h001;
                end
            end
            prs_pkg::SEQ_HOLD: begin
                if (cntDone) begin
                    state_d = prs_pkg::SEQ_SOFT;
                    cnt_d = prs_pkg::SOFT_LAG_CYC - 12'h001;
                end
            end
            prs_pkg::SEQ_SOFT: begin
                if (cntDone) begin
                    state_d = prs_pkg::SEQ_RUN;
                    cnt_d = prs_pkg::PIN_SETTLE_CYC;
                end
            end
            prs_pkg::SEQ_RUN: begin
                if (extHard || swHardReq) begin
                    state_d = prs_pkg::SEQ_HOLD;
                    cnt_d = prs_pkg::HARD_HOLD_CYC - 12'h001;
                end else if (extSoft) begin
                    state_d = prs_pkg::SEQ_SOFT;
                    cnt_d = prs_pkg::SOFT_LAG_CYC - 12'h001;
                end
            end
            default: begin
                state_d = prs_pkg::SEQ_POR;
            end
        endcase
        // Power-on reset overrides every state
        if (porLow) begin
            state_d = prs_pkg::SEQ_POR;
            cnt_d = 12'h000;
        end
    end

    // ****
    // Sequencer registers
    // ****
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_q <= prs_pkg::SEQ_POR;
            cnt_q <= 12'h000;
            porPrev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            porPrev_q <= powerOnResetInN;
        end
    end

    // Follow next state to switch with it
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            intPorN_q <= 1'b0;
            hardRstN_q <= 1'b0;
            softRstN_q <= 1'b0;
            clkEn_q <= 1'b0;
        end else begin
            intPorN_q <= (state_d != prs_pkg::SEQ_POR) &&
                         (state_d != prs_pkg::SEQ_CFG) &&
                         (state_d != prs_pkg::SEQ_HOST);
            hardRstN_q <= (state_d == prs_pkg::SEQ_SOFT) ||
                          (state_d == prs_pkg::SEQ_RUN);
            softRstN_q <= (state_d == prs_pkg::SEQ_RUN);
            clkEn_q <= porLow ? 1'b0 : (clkEn_q || (state_q == prs_pkg::SEQ_PLL &&
                       pllLocked));
        end
    end

    // ****
    // Strap capture
    // ****
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            strap_q <= '0;
        end else begin
            if (state_q == prs_pkg::SEQ_POR && porRise) begin
                strap_q.configRoleStrap <= straps.configRoleStrap;
                strap_q.hostPortEnableStrap <= straps.hostPortEnableStrap;
                strap_q.bootSourceStrap <= straps.bootSourceStrap;
            end
            if (state_q == prs_pkg::SEQ_CFG && cntDone) begin
                strap_q.clockModeStraps <= straps.clockModeStraps;
            end
            if (state_q == prs_pkg::SEQ_PLL && pllLocked) begin
                strap_q.debugRequestStrap <= straps.debugRequestStrap;
            end
        end
    end

    // ****
    // Configuration word and reset cause
    // ****
    // Only power-on reset reloads the word
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cfgWord_q <= prs_pkg::CFG_WORD_RST;
            hostBytes_q <= 3'h0;
        end else if (state_q == prs_pkg::SEQ_POR && porRise) begin
            cfgWord_q <= straps.hostPortEnableStrap ? prs_pkg::CFG_WORD_RST :
                         HW_CFG_WORD;
            hostBytes_q <= 3'h0;
        end else if (state_q == prs_pkg::SEQ_HOST && wrHost && !hostDone) begin
            cfgWord_q <= {cfgWord_q[23:0], wData_q[7:0]};
            hostBytes_q <= hostBytes_q + 3'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cause_q <= 4'h1;
        end else if (porLow) begin
            cause_q <= 4'h1;
        end else if (state_q == prs_pkg::SEQ_RUN) begin
            if (extHard || swHardReq || extSoft) begin
                cause_q <= {swHardReq, extSoft, extHard, 1'b0};
            end
        end
    end

    // ****
    // Output drive
    // ****
    assign internalPorN = intPorN_q;
    assign hardResetN = hardRstN_q;
    assign softResetN = softRstN_q;
    assign hardResetPinOut = 1'b0;
    assign hardResetPinOe = hardRstN_q;
    assign softResetPinOut = 1'b0;
    assign softResetPinOe = softRstN_q;
    assign pllStart = intPorN_q;
    assign pllRatio = {cfgWord_q[prs_pkg::CFG_MODCKH_LSB +: prs_pkg::CFG_MODCKH_W],
                       strap_q.clockModeStraps};
    assign dllBypass = bypassDll;
    assign clocksEnable = clkEn_q;
    assign debugMode = strap_q.debugRequestStrap;
    assign hostPortEnable = strap_q.hostPortEnableStrap;
    assign configMaster = !strap_q.configRoleStrap;
    assign bootSource = strap_q.bootSourceStrap;

    // ****
    // AXI4-Lite write channel
    // ****
    assign s_axi_awready = !awHeld_q && !bValid_q;
    assign s_axi_wready = !wHeld_q && !bValid_q;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
            bValid_q <= 1'b0;
            bResp_q <= prs_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (wrFire) begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                bValid_q <= 1'b1;
                bResp_q <= isMapped(awAddr_q) ? prs_pkg::RESP_OKAY :
                           prs_pkg::RESP_SLVERR;
            end else if (bValid_q && s_axi_bready) begin
                bValid_q <= 1'b0;
            end
        end
    end

    // ****
    // AXI4-Lite read channel
    // ****
    wire [31:0] statusWord = {13'h0000, hostBytes_q, strap_q, 1'b0, state_q, cause_q};
    wire [31:0] rdMux = (s_axi_araddr == prs_pkg::OFS_STATUS) ? statusWord :
                        (s_axi_araddr == prs_pkg::OFS_CFGWORD) ? cfgWord_q :
                        32'h0000_0000;

    assign s_axi_arready = !rValid_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata = rData_q;
    assign s_axi_rresp = rResp_q;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rValid_q <= 1'b0;
            rData_q <= 32'h0000_0000;
            rResp_q <= prs_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && !rValid_q) begin
            rValid_q <= 1'b1;
            rData_q <= rdMux;
            rResp_q <= isMapped(s_axi_araddr) ? prs_pkg::RESP_OKAY :
                       prs_pkg::RESP_SLVERR;
        end else if (rValid_q && s_axi_rready) begin
            rValid_q <= 1'b0;
        end
    end

endmodule

// ### prs_sync.sv
// Two-stage synchroniser for asynchronous level inputs
module prs_sync #(
    parameter int W = 2
) (
    input wire logic ref_clk,  // Clock
    input wire logic rstn,     // Synchronous reset, active low
    input wire logic [W-1:0] asyncIn,  // Raw levels
    output logic [W-1:0] syncOut       // Synchronised levels
);

    // ****
    // One flop chain per bit
    // ****
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_q;
            logic stab_q;
            always_ff @(posedge ref_clk) begin
                if (!rstn) begin
                    meta_q <= 1'b1;
                    stab_q <= 1'b1;
                end else begin
                    meta_q <= asyncIn[i];
                    stab_q <= meta_q;
                end
            end
            assign syncOut[i] = stab_q;
        end
    endgenerate

endmodule

// ### test_power_on_reset_sequencer.sv
// Testbench of the power-on reset sequencer
module test_power_on_reset_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
        $display("Error %0t: got %0h want %0h", $time, g, e); end end
    logic ref_clk = 1'b0, rstn = 1'b0, porReq = 1'b1, hardPull = 1'b0, softPull = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [11:0] lockCyc = 12'h010;
    prs_pkg::prs_strap_s straps = 8'h00, cur = 8'h00;
    logic powerOnResetInN, pllLocked, hardResetPinIn, softResetPinIn, hardResetPinOut;
    logic hardResetPinOe, softResetPinOut, softResetPinOe, internalPorN, hardResetN;
    logic softResetN, pllStart, dllBypass, clocksEnable, debugMode, hostPortEnable;
    logic configMaster, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, pPor, pInt, pClk, pSoft;
    logic [6:0] pllRatio;
    logic [1:0] bootSource, s_axi_bresp, s_axi_rresp;
    logic [2:0] hostCnt = 3'h0;
    logic [33:0] x;
    logic [33:0] rq[$];
    int tq[$];
    int fail_count = 0, n_compared = 0, cyc = 0, tA = 0, e;
    prs_sequencer u_dut (.*);
    prs_board_model u_board (.*);
    initial forever #20 ref_clk = ~ref_clk;
    // ****
    // Result watcher
    // ****
    always @(posedge ref_clk) begin
        cyc++;
        if (powerOnResetInN && !pPor) tA = cyc;
        if (clocksEnable && !pClk) tA = cyc;
        if (internalPorN === 1'b1 && !pInt) begin
            e = tq.pop_front();
            if (e > 0) `CHK(cyc - tA, e)
        end
        if (softResetN === 1'b1 && !pSoft && tq.size() > 0) begin
            e = tq.pop_front();
            `CHK(cyc - tA, e)
        end
        if (s_axi_bvalid && s_axi_bready) begin
            x = rq.pop_front();
            `CHK(s_axi_bresp, x[33:32])
        end
        if (s_axi_rvalid && s_axi_rready) begin
            x = rq.pop_front();
            `CHK({s_axi_rresp, s_axi_rdata}, x)
        end
        {pPor, pInt, pClk, pSoft} = {powerOnResetInN, internalPorN, clocksEnable, softResetN};
    end
    task automatic summarize();
        if (fail_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
            input logic [33:0] xp);
        int i;
        rq.push_back(xp);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
        i = 0;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) s_axi_bready <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) s_axi_rready <= 1'b0;
            i++;
        end while (i < 200 && (s_axi_bready || s_axi_rready));
        if (i == 200) begin fail_count++; summarize(); end
    endtask
    task automatic waitFor(input logic [1:0] want);
        int i;
        for (i = 0; i < 9000; i++) begin
            @(posedge ref_clk);
            if ({powerOnResetInN, softResetN} === want) break;
        end
        if (i == 9000) begin fail_count++; summarize(); end
    endtask
    function automatic logic [33:0] st(input logic [3:0] c);
        return {prs_pkg::RESP_OKAY, 13'h0000, hostCnt, cur, 1'b0, prs_pkg::SEQ_RUN, c};
    endfunction
    task automatic runSeq(input logic host, input logic [31:0] w);
        int i;
        prs_pkg::prs_strap_s s;
        s = prs_pkg::prs_strap_s'($urandom);
        s.bootSourceStrap[1] = 1'b0;
        s.hostPortEnableStrap = host;
        s.configRoleStrap = s.configRoleStrap | host;
        straps <= s;
        lockCyc <= 12'(($urandom % 900) + 1);
        porReq <= 1'b1;
        tq.push_back(host ? 0 : int'(prs_pkg::CFG_CYC) + 1);
        tq.push_back(int'(prs_pkg::HARD_HOLD_CYC + prs_pkg::SOFT_LAG_CYC
            + (w[15] ? 12'h000 : prs_pkg::DLL_LOCK_CYC)));
        @(posedge ref_clk);
        porReq <= 1'b0;
        // Pulls while the device drives must not count as a cause
        hardPull <= 1'b1;
        repeat (40) @(posedge ref_clk);
        hardPull <= 1'b0;
        if (host) begin
            waitFor(2'b10);
            repeat (1030) @(posedge ref_clk);
            for (i = 0; i < 5; i++) begin
                if (i == 3) `CHK(internalPorN, 1'b0)
                axi(1'b1, prs_pkg::OFS_HOSTCFG, {24'h00_0000, 8'(w >> (24 - 8 * i))},
                    {prs_pkg::RESP_OKAY, 32'h0000_0000});
            end
        end
        waitFor(2'b11);
        hostCnt = host ? 3'h4 : 3'h0;
        cur = s;
        `CHK(configMaster, !s.configRoleStrap)
        `CHK(hostPortEnable, host)
        `CHK(bootSource, s.bootSourceStrap)
        `CHK(debugMode, s.debugRequestStrap)
        `CHK(pllRatio, {w[27:24], s.clockModeStraps})
        `CHK(dllBypass, w[15])
        axi(1'b0, prs_pkg::OFS_CFGWORD, 32'h0000_0000, {prs_pkg::RESP_OKAY, w});
        axi(1'b0, prs_pkg::OFS_STATUS, 32'h0000_0000, st(4'h1));
    endtask
    initial begin
        int k;
        void'($urandom(32'h5be07fad));
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        runSeq(1'b0, prs_pkg::CFG_WORD_RST);
        axi(1'b0, 8'h40, 32'h0000_0000, {prs_pkg::RESP_SLVERR, 32'h0000_0000});
        axi(1'b1, 8'h40, 32'hFFFF_FFFF, {prs_pkg::RESP_SLVERR, 32'h0000_0000});
        axi(1'b1, prs_pkg::OFS_STATUS, 32'hFFFF_FFFF, {prs_pkg::RESP_OKAY, 32'h0000_0000});
        // Sources in turn: hard pin, soft pin, software hard reset
        for (k = 1; k < 4; k++) begin
            if (k == 3) begin
                axi(1'b1, prs_pkg::OFS_CONTROL, 32'h0000_0001, st(4'h0));
            end else begin
                {hardPull, softPull} <= {k == 1, k == 2};
                repeat (2) @(posedge ref_clk);
                {hardPull, softPull} <= 2'b00;
            end
            waitFor(2'b10);
            `CHK(hardResetN, k == 2)
            waitFor(2'b11);
            axi(1'b0, prs_pkg::OFS_STATUS, 32'h0000_0000, st(4'(1 << k)));
            `CHK(pllRatio, {4'h0, cur.clockModeStraps})
        end
        runSeq(1'b1, $urandom | 32'h0000_8000);
        summarize();
    end
endmodule
